// File: tcc_pkg.sv
// package of constants for the timer control-one block
package tcc_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0]  CTRL_ONE_OFF   = 8'h00;
    localparam logic [7:0]  EVT_GEN_OFF    = 8'h04;
    localparam logic [7:0]  STATUS_OFF     = 8'h08;
    localparam logic [7:0]  MASK_OFF       = 8'h0c;
    localparam logic [7:0]  COUNT_OFF      = 8'h10;
    localparam logic [7:0]  RELOAD_OFF     = 8'h14;
    localparam logic [7:0]  MODE_OFF       = 8'h18;
    // ****************************************************************
    // control-one fields
    // ****************************************************************
    localparam int          RUN_BIT        = 0;
    localparam int          INHIBIT_BIT    = 1;
    localparam int          SOURCE_BIT     = 2;
    localparam int          SHOT_BIT       = 3;
    localparam int          DIR_BIT        = 4;
    localparam int          ALIGN_LSB      = 5;
    localparam logic [6:0]  CTRL_RESET     = 7'h00;
    localparam logic [1:0]  ALIGN_EDGE     = 2'h0;
    localparam logic [1:0]  ALIGN_DOWN     = 2'h1;
    localparam logic [1:0]  ALIGN_UP       = 2'h2;
    localparam logic [1:0]  ALIGN_BOTH     = 2'h3;
    // ****************************************************************
    // status bits, slave modes, defaults
    // ****************************************************************
    localparam int          ST_UPDATE      = 0;
    localparam int          ST_COMPARE     = 1;
    localparam int          ST_TRIGGER     = 2;
    localparam logic [2:0]  SLV_OFF        = 3'h0;
    localparam logic [2:0]  SLV_ENCODER    = 3'h1;
    localparam logic [2:0]  SLV_PAUSE      = 3'h5;
    localparam logic [2:0]  SLV_EVENT      = 3'h6;
    localparam logic [2:0]  SLV_EXTCLK     = 3'h7;
    localparam logic [15:0] RELOAD_RESET   = 16'hffff;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// File: tcc_counter.sv
// counter core: edge or center-aligned counting with reload and compare
`timescale 1ns/1ps
module tcc_counter import tcc_pkg::*; #(
    parameter int WIDTH = 16
) (
    // clock and control
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             clk_en,
    input  wire logic             run,
    input  wire logic [1:0]       align,
    input  wire logic             dir_sw,
    input  wire logic             reinit,
    input  wire logic             load_shadow,
    input  wire logic [WIDTH-1:0] reload_pre,
    input  wire logic [WIDTH-1:0] compare_val,
    // state and events
    output logic [WIDTH-1:0]      count,
    output logic                  dir_now,
    output logic                  wrap,
    output logic                  cmp_up,
    output logic                  cmp_down
);
    logic [WIDTH-1:0] reload_ff, nxt_reload;
    logic [WIDTH-1:0] cnt_ff,    nxt_cnt;
    logic             cdir_ff,   nxt_cdir;
    logic             hit;

    // next count; center modes fold at the reload and at zero
    always_comb begin
        nxt_reload = load_shadow ? reload_pre : reload_ff;
        nxt_cnt    = cnt_ff;
        nxt_cdir   = cdir_ff;
        wrap       = 1'b0;
        if (reinit) begin
            nxt_cnt  = (align == ALIGN_EDGE && dir_sw) ? reload_ff : '0;
            nxt_cdir = 1'b0;
        end else if (run) begin
            if (align == ALIGN_EDGE) begin
                if (!dir_sw) begin
                    wrap    = (cnt_ff >= reload_ff);
                    nxt_cnt = wrap ? '0 : cnt_ff + 1'b1;
                end else begin
                    wrap    = (cnt_ff == '0);
                    nxt_cnt = wrap ? reload_ff : cnt_ff - 1'b1;
                end
            end else if (!cdir_ff) begin
                if (cnt_ff + 1'b1 >= reload_ff) begin
                    wrap     = 1'b1;
                    nxt_cdir = 1'b1;
                end
                nxt_cnt = cnt_ff + 1'b1;
            end else begin
                if (cnt_ff == {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    wrap     = 1'b1;
                    nxt_cdir = 1'b0;
                end
                nxt_cnt = cnt_ff - 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload_ff <= RELOAD_RESET[WIDTH-1:0];
            cnt_ff    <= '0;
            cdir_ff   <= 1'b0;
        end else if (clk_en) begin
            reload_ff <= nxt_reload;
            cnt_ff    <= nxt_cnt;
            cdir_ff   <= nxt_cdir;
        end
    end

    // compare match, split by the direction of travel
    assign hit      = run && !reinit && (cnt_ff == compare_val);
    assign dir_now  = (align == ALIGN_EDGE) ? dir_sw : cdir_ff;
    assign cmp_up   = hit && !dir_now;
    assign cmp_down = hit && dir_now;
    assign count    = cnt_ff;
endmodule // tcc_counter

// File: tcc_top.sv
// timer control-one block with axi4-lite registers and interrupt
`timescale 1ns/1ps
module tcc_top import tcc_pkg::*; #(
    parameter int WIDTH = 16
) (
    // clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // slave controller events, same clock
    input  wire logic        slave_update,
    input  wire logic        slave_reset,
    input  wire logic        slave_trigger,
    // outputs
    output logic             update_event,
    output logic             update_request,
    output logic             irq
);
    // ****************************************************************
    // state
    // ****************************************************************
    logic [6:0]       ctrl_ff,    nxt_ctrl;
    logic [2:0]       stat_ff,    nxt_stat;
    logic [2:0]       mask_ff,    nxt_mask;
    logic [2:0]       smode_ff,   nxt_smode;
    logic             chout_ff,   nxt_chout;
    logic [WIDTH-1:0] rpre_ff,    nxt_rpre;
    logic [WIDTH-1:0] cmp_ff,     nxt_cmp;
    logic             aw_ff,      nxt_aw;
    logic             w_ff,       nxt_w;
    logic [7:0]       awa_ff,     nxt_awa;
    logic [31:0]      wd_ff,      nxt_wd;
    logic             bv_ff,      nxt_bv;
    logic [1:0]       br_ff,      nxt_br;
    logic             rv_ff,      nxt_rv;
    logic [31:0]      rd_ff,      nxt_rd;
    logic [1:0]       rr_ff,      nxt_rr;
    logic             ue_ff,      nxt_ue;
    logic             ur_ff,      nxt_ur;
    logic             irq_ff,     nxt_irq;
    logic             ug_ff,      nxt_ug;
    logic             awrdy_ff,   nxt_awrdy;
    logic             wrdy_ff,    nxt_wrdy;
    logic             arrdy_ff,   nxt_arrdy;
    logic [WIDTH-1:0] count;
    logic             dir_now, wrap, cmp_up, cmp_down;
    logic             do_wr, do_rd, run, upd_evt, upd_flag, reinit, cmp_flag;
    logic             center, dir_locked;

    // register decode, shared by read and write paths
    function automatic logic known_addr(input logic [7:0] a);
        if (a == CTRL_ONE_OFF) return 1'b1;
        else if (a == EVT_GEN_OFF) return 1'b1;
        else if (a == STATUS_OFF) return 1'b1;
        else if (a == MASK_OFF) return 1'b1;
        else if (a == COUNT_OFF) return 1'b1;
        else if (a == RELOAD_OFF) return 1'b1;
        else if (a == MODE_OFF) return 1'b1;
        else return 1'b0;
    endfunction

    // ****************************************************************
    // counter core
    // ****************************************************************
    assign run    = ctrl_ff[RUN_BIT];
    assign center = ctrl_ff[ALIGN_LSB+1:ALIGN_LSB] != ALIGN_EDGE;
    // update-generate is a one-cycle pulse so it lines up with slave events
    // an inhibited slave update leaves the count alone; a slave reset never does
    assign reinit = ug_ff || slave_reset || (slave_update && !ctrl_ff[INHIBIT_BIT]);
    assign upd_evt = !ctrl_ff[INHIBIT_BIT] && (ug_ff || wrap || slave_update);
    assign upd_flag = upd_evt && (!ctrl_ff[SOURCE_BIT] || wrap);

    // compare flag gating by alignment, output channels only
    always_comb begin
        cmp_flag = 1'b0;
        if (!chout_ff) cmp_flag = cmp_up || cmp_down;
        else begin
            case (ctrl_ff[ALIGN_LSB+1:ALIGN_LSB])
                ALIGN_EDGE: cmp_flag = cmp_up || cmp_down;
                ALIGN_DOWN: cmp_flag = cmp_down;
                ALIGN_UP:   cmp_flag = cmp_up;
                default:    cmp_flag = cmp_up || cmp_down;
            endcase
        end
    end

    tcc_counter #(.WIDTH(WIDTH)) u_counter (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .clk_en      (clk_en),
        .run         (run),
        .align       (ctrl_ff[ALIGN_LSB+1:ALIGN_LSB]),
        .dir_sw      (ctrl_ff[DIR_BIT]),
        .reinit      (reinit),
        .load_shadow (upd_evt),
        .reload_pre  (rpre_ff),
        .compare_val (cmp_ff),
        .count       (count),
        .dir_now     (dir_now),
        .wrap        (wrap),
        .cmp_up      (cmp_up),
        .cmp_down    (cmp_down)
    );

    // ****************************************************************
    // bus handshake and register next values
    // ****************************************************************
    // a write executes once both halves are held and no response is pending;
    // a new address may be taken while the response waits, it just stays held
    assign do_wr      = aw_ff && w_ff && !bv_ff;
    assign do_rd      = s_axi_arvalid && !rv_ff;
    assign dir_locked = center || (smode_ff == SLV_ENCODER);

    // write path, hardware updates and sticky status
    always_comb begin
        nxt_aw = aw_ff;
        nxt_w = w_ff;
        nxt_awa = awa_ff;
        nxt_wd = wd_ff;
        nxt_bv = bv_ff;
        nxt_br = br_ff;
        nxt_ctrl = ctrl_ff;
        nxt_mask = mask_ff;
        nxt_smode = smode_ff;
        nxt_chout = chout_ff;
        nxt_rpre = rpre_ff;
        nxt_cmp = cmp_ff;
        nxt_ug = 1'b0;
        nxt_stat = stat_ff;
        if (s_axi_awvalid && !aw_ff) begin
            nxt_aw  = 1'b1;
            nxt_awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_ff) begin
            nxt_w  = 1'b1;
            nxt_wd = s_axi_wdata;
        end
        if (bv_ff && s_axi_bready) nxt_bv = 1'b0;
        if (do_wr) begin
            nxt_aw = 1'b0;
            nxt_w  = 1'b0;
            nxt_bv = 1'b1;
            nxt_br = known_addr(awa_ff) ? RESP_OKAY : RESP_SLVERR;
            if (awa_ff == CTRL_ONE_OFF) begin
                nxt_ctrl = wd_ff[6:0];
                if (dir_locked) nxt_ctrl[DIR_BIT] = ctrl_ff[DIR_BIT];
            end else if (awa_ff == EVT_GEN_OFF) begin
                nxt_ug = wd_ff[0];
            end else if (awa_ff == STATUS_OFF) begin
                nxt_stat = stat_ff & ~wd_ff[2:0];
            end else if (awa_ff == MASK_OFF) begin
                nxt_mask = wd_ff[2:0];
            end else if (awa_ff == RELOAD_OFF) begin
                nxt_rpre = wd_ff[WIDTH-1:0];
            end else if (awa_ff == MODE_OFF) begin
                nxt_smode = wd_ff[2:0];
                nxt_chout = wd_ff[4];
                nxt_cmp   = wd_ff[16+WIDTH-1:16];
            end
        end
        // hardware events; each beats a same-cycle register write
        if (upd_evt && ctrl_ff[SHOT_BIT]) nxt_ctrl[RUN_BIT] = 1'b0;
        if (slave_trigger && smode_ff == SLV_EVENT) nxt_ctrl[RUN_BIT] = 1'b1;
        if (center) nxt_ctrl[DIR_BIT] = dir_now;
        if (upd_flag) nxt_stat[ST_UPDATE] = 1'b1;
        if (cmp_flag) nxt_stat[ST_COMPARE] = 1'b1;
        if (slave_trigger) nxt_stat[ST_TRIGGER] = 1'b1;
        nxt_ue  = upd_evt;
        nxt_ur  = upd_flag;
        // irq follows next status and mask so it lands with them
        nxt_irq = |(nxt_stat & nxt_mask);
        // ready mirrors an empty holding slot, kept in a flop for a clean pin
        nxt_awrdy = !nxt_aw;
        nxt_wrdy  = !nxt_w;
    end

    // read path; one-cycle read answer
    // trade-off: count is sampled when the address is taken, so by the time
    // rvalid is seen the value is one cycle old
    always_comb begin
        nxt_rv = rv_ff;
        nxt_rd = rd_ff;
        nxt_rr = rr_ff;
        if (rv_ff && s_axi_rready) nxt_rv = 1'b0;
        if (do_rd) begin
            nxt_rv = 1'b1;
            nxt_rr = known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            nxt_rd = 32'h0000_0000;
            if (s_axi_araddr == CTRL_ONE_OFF) nxt_rd[6:0] = ctrl_ff;
            else if (s_axi_araddr == STATUS_OFF) nxt_rd[2:0] = stat_ff;
            else if (s_axi_araddr == MASK_OFF) nxt_rd[2:0] = mask_ff;
            else if (s_axi_araddr == COUNT_OFF) nxt_rd[WIDTH-1:0] = count;
            else if (s_axi_araddr == RELOAD_OFF) nxt_rd[WIDTH-1:0] = rpre_ff;
            else if (s_axi_araddr == MODE_OFF) begin
                nxt_rd[2:0] = smode_ff;
                nxt_rd[4]   = chout_ff;
                nxt_rd[16+WIDTH-1:16] = cmp_ff;
            end
        end
        // no new address while an answer stands
        nxt_arrdy = !nxt_rv;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // all state holds while clk_en is low, the bus handshake included
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= CTRL_RESET;
            stat_ff <= 3'h0;
            mask_ff <= 3'h0;
            smode_ff <= SLV_OFF;
            chout_ff <= 1'b0;
            rpre_ff <= RELOAD_RESET[WIDTH-1:0];
            cmp_ff <= '0;
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awa_ff <= 8'h00;
            wd_ff <= 32'h0000_0000;
            bv_ff <= 1'b0;
            br_ff <= RESP_OKAY;
            rv_ff <= 1'b0;
            rd_ff <= 32'h0000_0000;
            rr_ff <= RESP_OKAY;
            ue_ff <= 1'b0;
            ur_ff <= 1'b0;
            irq_ff <= 1'b0;
            ug_ff <= 1'b0;
            awrdy_ff <= 1'b1;
            wrdy_ff <= 1'b1;
            arrdy_ff <= 1'b1;
        end else if (clk_en) begin
            ctrl_ff <= nxt_ctrl;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
            smode_ff <= nxt_smode;
            chout_ff <= nxt_chout;
            rpre_ff <= nxt_rpre;
            cmp_ff <= nxt_cmp;
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            awa_ff <= nxt_awa;
            wd_ff <= nxt_wd;
            bv_ff <= nxt_bv;
            br_ff <= nxt_br;
            rv_ff <= nxt_rv;
            rd_ff <= nxt_rd;
            rr_ff <= nxt_rr;
            ue_ff <= nxt_ue;
            ur_ff <= nxt_ur;
            irq_ff <= nxt_irq;
            ug_ff <= nxt_ug;
            awrdy_ff <= nxt_awrdy;
            wrdy_ff <= nxt_wrdy;
            arrdy_ff <= nxt_arrdy;
        end
    end

    // ready flags are registers: accept only while the holding slot is empty
    // limitation: wstrb is ignored, every write acts as if all four byte strobes were set
    assign s_axi_awready  = awrdy_ff;
    assign s_axi_wready   = wrdy_ff;
    assign s_axi_arready  = arrdy_ff;
    assign s_axi_bvalid   = bv_ff;
    assign s_axi_bresp    = br_ff;
    assign s_axi_rvalid   = rv_ff;
    assign s_axi_rdata    = rd_ff;
    assign s_axi_rresp    = rr_ff;
    assign update_event   = ue_ff;
    assign update_request = ur_ff;
    assign irq            = irq_ff;
endmodule // tcc_top

// File: tcc_top_sva.sv
// concurrent checks on the ports of the timer control-one block
`timescale 1ns/1ps
module tcc_top_sva (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    // events
    input wire logic        slave_update,
    input wire logic        update_event,
    input wire logic        update_request
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic       wr_take;
    logic [2:0] sw_ff; // run, inhibit, source as software last wrote them
    assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    // shadow of written bits; a hardware trigger may set run unseen, so checks need run clear
    always_ff @(posedge aclk) begin
        if (!aresetn) sw_ff <= 3'h0;
        else if (wr_take && s_axi_awaddr == 8'h00) sw_ff <= s_axi_wdata[2:0];
    end
    sequence s_gen_write;
        wr_take && s_axi_awaddr == 8'h04 && s_axi_wdata[0];
    endsequence
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_gen_event;
        s_gen_write ##0 !sw_ff[1] |-> ##[1:4] update_event;
    endproperty
    property p_gen_request;
        s_gen_write ##0 sw_ff[2:1] == 2'h0 |-> ##[1:4] update_request;
    endproperty
    property p_slv_request;
        slave_update && sw_ff[2:1] == 2'h0 |-> ##[1:4] update_request;
    endproperty
    property p_inhibit_quiet;
        s_gen_write ##0 (sw_ff[1] && !sw_ff[0]) |-> ##1 !update_event [*4];
    endproperty
    property p_source_filter;
        s_gen_write ##0 (sw_ff[2] && !sw_ff[0]) |-> ##1 !update_request [*4];
    endproperty
    property p_req_with_event;
        update_request |-> update_event;
    endproperty
    property p_read_latency;
        s_ar_take |=> s_axi_rvalid;
    endproperty
    property p_read_slverr;
        s_ar_take ##0 (s_axi_araddr > 8'h18 || s_axi_araddr[1:0] != 2'h0)
            |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endproperty
    property p_write_resp;
        wr_take |-> ##[1:2] s_axi_bvalid;
    endproperty
    property p_resp_release;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
    endproperty
    a_gen_event: assert property (p_gen_event) else $error("no update event");
    a_gen_request: assert property (p_gen_request) else $error("no request");
    a_slv_request: assert property (p_slv_request) else $error("no slave request");
    a_inhibit_quiet: assert property (p_inhibit_quiet) else $error("inhibit leak");
    a_source_filter: assert property (p_source_filter) else $error("filter leak");
    a_req_with_event: assert property (p_req_with_event) else $error("lone request");
    a_read_latency: assert property (p_read_latency) else $error("read late");
    a_read_slverr: assert property (p_read_slverr) else $error("bad unmapped read");
    a_write_resp: assert property (p_write_resp) else $error("write response late");
    a_resp_release: assert property (p_resp_release) else $error("write channel stuck");
endmodule // tcc_top_sva

bind tcc_top tcc_top_sva u_tcc_top_sva (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .slave_update(slave_update), .update_event(update_event), .update_request(update_request));

// File: tcc_top_tb.sv
// self-checking bench for the timer control-one block
`timescale 1ns/1ps
module tcc_top_tb import tcc_pkg::*; ;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, ctl;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  slv = 3'h0; // update, reset, trigger pulses
    logic        update_event, update_request, irq;
    int          n_mismatch = 0, num_checks = 0, n_ev = 0, n_req = 0, ev0, rq0;
    // clk_en and wstrb stay constant: freezing is not exercised here
    tcc_top u_tcc_top (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .slave_update(slv[0]),
        .slave_reset(slv[1]), .slave_trigger(slv[2]), .update_event(update_event),
        .update_request(update_request), .irq(irq));
    always #2.5 aclk = ~aclk;
    // count event pulses so tests compare deltas
    always @(posedge aclk) begin
        if (update_event === 1'b1) n_ev++;
        if (update_request === 1'b1) n_req++;
    end
    // ****************************************************************
    // bus tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // unmapped offsets above the map answer with an error code
    function automatic logic [1:0] resp_of(input logic [7:0] a);
        return (a > MODE_OFF) ? RESP_SLVERR : RESP_OKAY;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_left, w_left;
        aw_left = 1'b1;
        w_left = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw_left || w_left) begin
            @(posedge aclk);
            if (aw_left && s_axi_awready) begin
                aw_left = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_left && s_axi_wready) begin
                w_left = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        chk({30'h0, s_axi_bresp}, {30'h0, resp_of(a)});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        chk({30'h0, s_axi_rresp}, {30'h0, resp_of(a)});
        chk(s_axi_rdata & m, exp);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic pulse(input int k);
        slv[k] <= 1'b1;
        @(posedge aclk);
        slv <= 3'h0;
        @(posedge aclk);
    endtask
    // bounded wait for event pulses since ev0
    task automatic wait_ev(input int n);
        for (int t = 0; t < 300 && n_ev - ev0 < n; t++) @(posedge aclk);
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(CTRL_ONE_OFF, 32'h7f, 32'h0);
        rd_chk(RELOAD_OFF, 32'hffff, {16'h0, RELOAD_RESET});
        rd_chk(8'h1c, 32'hffffffff, 32'h0);
        wr(8'h1c, 32'h1);
        // generate and slave update with no filter, with source set and with inhibit set
        for (int i = 0; i < 6; i++) begin
            ctl = (i < 2) ? 32'h0 : (i < 4) ? 32'h4 : 32'h2;
            wr(CTRL_ONE_OFF, ctl);
            ev0 = n_ev;
            rq0 = n_req;
            if (i % 2 == 0) wr(EVT_GEN_OFF, 32'h1);
            else pulse(0);
            repeat (4) @(posedge aclk);
            chk(32'(n_ev - ev0), ctl[1] ? 32'h0 : 32'h1);
            chk(32'(n_req - rq0), (ctl[2:1] == 2'h0) ? 32'h1 : 32'h0);
        end
        // inhibited slave reset still restarts the count
        wr(CTRL_ONE_OFF, 32'h3);
        repeat (40) @(posedge aclk);
        pulse(1);
        rd_chk(COUNT_OFF, 32'hfff0, 32'h0);
        wr(CTRL_ONE_OFF, 32'h0);
        // short period, then single shot with the interrupt armed
        wr(RELOAD_OFF, 32'h7);
        wr(EVT_GEN_OFF, 32'h1);
        wr(STATUS_OFF, 32'h7);
        wr(MASK_OFF, 32'h1);
        chk({31'h0, irq}, 32'h0);
        ev0 = n_ev;
        wr(CTRL_ONE_OFF, 32'h9);
        wait_ev(1);
        repeat (3) @(posedge aclk);
        rd_chk(CTRL_ONE_OFF, 32'h1, 32'h0);
        chk({31'h0, irq}, 32'h1);
        rd_chk(STATUS_OFF, 32'h1, 32'h1);
        wr(STATUS_OFF, 32'h1);
        chk({31'h0, irq}, 32'h0);
        // masked status stays silent until the mask opens
        wr(MASK_OFF, 32'h0);
        wr(EVT_GEN_OFF, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(MASK_OFF, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(STATUS_OFF, 32'h7);
        // continuous mode keeps running across updates
        ev0 = n_ev;
        wr(CTRL_ONE_OFF, 32'h1);
        wait_ev(2);
        rd_chk(CTRL_ONE_OFF, 32'h1, 32'h1);
        chk(32'(n_ev - ev0 >= 2), 32'h1);
        wr(CTRL_ONE_OFF, 32'h0);
        wr(CTRL_ONE_OFF, 32'h10);
        rd_chk(CTRL_ONE_OFF, 32'h10, 32'h10);
        wr(CTRL_ONE_OFF, 32'h0);
        // each alignment reads back as written; a write from center mode keeps the direction bit
        for (int a = 0; a < 4; a++) begin
            wr(CTRL_ONE_OFF, 32'(a) << 5);
            rd_chk(CTRL_ONE_OFF, 32'h60, 32'(a) << 5);
        end
        wr(CTRL_ONE_OFF, 32'h30);
        rd_chk(CTRL_ONE_OFF, 32'h70, 32'h20);
        wr(CTRL_ONE_OFF, 32'h0);
        // event mode: trigger starts the counter
        wr(MODE_OFF, {29'h0, SLV_EVENT});
        pulse(2);
        rd_chk(CTRL_ONE_OFF, 32'h1, 32'h1);
        wr(CTRL_ONE_OFF, 32'h0);
        // output channel comparing at the reload value: that hit only comes counting down
        wr(MODE_OFF, 32'h0007_0010);
        for (int a = 1; a < 4; a++) begin
            wr(CTRL_ONE_OFF, 32'(a) << 5);
            wr(EVT_GEN_OFF, 32'h1);
            wr(STATUS_OFF, 32'h7);
            wr(CTRL_ONE_OFF, (32'(a) << 5) | 32'h1);
            repeat (20) @(posedge aclk);
            wr(CTRL_ONE_OFF, 32'(a) << 5);
            rd_chk(STATUS_OFF, 32'h2, (a == 2) ? 32'h0 : 32'h2);
        end
        wr(CTRL_ONE_OFF, 32'h0);
        wr(MODE_OFF, 32'h0);
        wrap_up();
    end
    // watchdog sized well past the whole sequence
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        wrap_up();
    end
endmodule // tcc_top_tb
